// ### include/hbp_pkg.sv
package hbp_pkg;

	// =====================================================================
	// Clock and timing figures, in their own units.
	localparam int unsigned REF_CLK_MHZ       = 125;
	localparam int unsigned WAKE_READY_US     = 10;
	localparam int unsigned STANDBY_RETURN_US = 8;
	localparam int unsigned STARTUP_US        = 360;
	localparam int unsigned BLANK_US          = 65;
	localparam int unsigned BLANK_PWM_US      = 10;
	localparam int unsigned OC_FILTER_US      = 5;
	localparam int unsigned ULD_FILTER_US     = 20;
	localparam int unsigned SUPPLY_FILTER_US  = 10;
	localparam int unsigned THERMAL_FILTER_US = 10;
	localparam int unsigned RETRY_BASE_US     = 100;
	localparam int unsigned DEAD_NS           = 500;

	// Cycle counts: least times round up, longest times round down.
	localparam int unsigned WAKE_READY_CYC     = WAKE_READY_US * REF_CLK_MHZ;
	localparam int unsigned STANDBY_RETURN_CYC = STANDBY_RETURN_US * REF_CLK_MHZ;
	localparam int unsigned STARTUP_CYC        = STARTUP_US * REF_CLK_MHZ;
	localparam int unsigned BLANK_CYC          = BLANK_US * REF_CLK_MHZ;
	localparam int unsigned BLANK_PWM_CYC      = BLANK_PWM_US * REF_CLK_MHZ;
	localparam int unsigned OC_FILTER_CYC      = OC_FILTER_US * REF_CLK_MHZ;
	localparam int unsigned ULD_FILTER_CYC     = ULD_FILTER_US * REF_CLK_MHZ;
	localparam int unsigned SUPPLY_FILTER_CYC  = SUPPLY_FILTER_US * REF_CLK_MHZ;
	localparam int unsigned THERMAL_FILTER_CYC = THERMAL_FILTER_US * REF_CLK_MHZ;
	localparam int unsigned RETRY_BASE_CYC     = RETRY_BASE_US * REF_CLK_MHZ;
	localparam int unsigned DEAD_CYC           = (DEAD_NS * REF_CLK_MHZ + 999) / 1000;

	// Width of every timing counter.
	localparam int unsigned CNT_W = 17;

	// =====================================================================
	// Command decode on the link.
	localparam logic [1:0] OP_READ_CLEAR = 2'h2;
	localparam logic [5:0] ADDR_OC_STAT  = 6'h10;
	localparam logic [5:0] ADDR_ULD_STAT = 6'h11;
	localparam logic [5:0] ADDR_SUP_STAT = 6'h12;

	// Sense select codes naming each output.
	localparam logic [2:0] SENSE_SEL_OUT1 = 3'h1;
	localparam logic [2:0] SENSE_SEL_OUT2 = 3'h2;

	// Positions of the condition bits inside the synchronised pin vector.
	localparam int unsigned PIN_OC  = 0;
	localparam int unsigned PIN_ULD = 4;
	localparam int unsigned PIN_SOV = 6;
	localparam int unsigned PIN_SUV = 7;
	localparam int unsigned PIN_TW  = 8;
	localparam int unsigned PIN_TSD = 9;
	localparam int unsigned PIN_PWM = 10;
	localparam int unsigned PIN_CSN = 12;
	localparam int unsigned N_COND  = 10;

	// =====================================================================
	// Types.
	typedef enum logic [4:0] {
		MODE_STANDBY = 5'h01,
		MODE_WAKE    = 5'h02,
		MODE_STARTUP = 5'h04,
		MODE_ACTIVE  = 5'h08,
		MODE_LEAVING = 5'h10
	} mode_t;

	typedef struct packed {
		logic       chip_select_n;
		logic [1:0] pwm_in;
		logic       thermal_shut_raw;
		logic       thermal_warn_raw;
		logic       supply_under_raw;
		logic       supply_over_raw;
		logic [1:0] underload_raw;
		logic [3:0] overcurrent_raw;
	} pins_t;

	typedef struct packed {
		logic            mode_bit;
		logic [1:0]      out_hs;
		logic [1:0]      out_ls;
		logic [1:0]      out_pwm_en;
		logic [1:0]      overcurrent_retry_select;
		logic [1:0][1:0] retry_rate_sel;
		logic            supply_fault_recovery_select;
		logic [2:0]      sense_channel_select;
	} ctrl_t;

	typedef struct packed {
		logic       global_supply_or_overcurrent_flag;
		logic       thermal_shutdown_flag;
		logic       thermal_warning_flag;
		logic       supply_over_flag;
		logic       supply_under_flag;
		logic [1:0] per_channel_underload_flags;
		logic [3:0] per_driver_overcurrent_flags;
	} status_t;

	typedef struct packed {
		logic [1:0] hs;
		logic [1:0] ls;
	} drive_t;

	typedef struct packed {
		logic [1:0] route;
		logic       track;
		logic       hold;
		logic       zero;
	} sense_t;

endpackage

// ### verilog/half_bridge_protection_mode_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module half_bridge_protection_mode_ctrl #(
	parameter int unsigned WAKE_READY_CYC     = hbp_pkg::WAKE_READY_CYC,
	parameter int unsigned STANDBY_RETURN_CYC = hbp_pkg::STANDBY_RETURN_CYC,
	parameter int unsigned STARTUP_CYC        = hbp_pkg::STARTUP_CYC,
	parameter int unsigned BLANK_CYC          = hbp_pkg::BLANK_CYC,
	parameter int unsigned BLANK_PWM_CYC      = hbp_pkg::BLANK_PWM_CYC,
	parameter int unsigned OC_FILTER_CYC      = hbp_pkg::OC_FILTER_CYC,
	parameter int unsigned ULD_FILTER_CYC     = hbp_pkg::ULD_FILTER_CYC,
	parameter int unsigned SUPPLY_FILTER_CYC  = hbp_pkg::SUPPLY_FILTER_CYC,
	parameter int unsigned THERMAL_FILTER_CYC = hbp_pkg::THERMAL_FILTER_CYC,
	parameter int unsigned RETRY_BASE_CYC     = hbp_pkg::RETRY_BASE_CYC,
	parameter int unsigned DEAD_CYC           = hbp_pkg::DEAD_CYC
) (
	// Core clock, reset and clock enable.
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	input  wire logic                clk_en,
	// Link side, running on the link's own clock.
	input  wire logic                link_clk,
	input  wire logic                cmd_valid,
	input  wire logic [1:0]          cmd_opcode,
	input  wire logic [5:0]          cmd_addr,
	// Pins and comparator outputs, asynchronous to ref_clk.
	input  wire hbp_pkg::pins_t      pins,
	// Control bits from the register file.
	input  wire hbp_pkg::ctrl_t      ctrl,
	// Power stage gates, status and sense steering.
	output var  hbp_pkg::drive_t     drive,
	output var  hbp_pkg::status_t    status,
	output var  hbp_pkg::sense_t     sense,
	// Mode reporting.
	output var  hbp_pkg::mode_t      mode_state,
	output var  logic                spi_ready,
	output var  logic                standby_clear
);

	localparam int unsigned W = hbp_pkg::CNT_W;

	// =====================================================================
	// State types of the two clock domains.

	// Link domain state: reset synchroniser and one toggle per status register.
	typedef struct packed {
		logic       rst_s1;
		logic       rst_s2;
		logic [2:0] clr_tgl;
	} link_state_t;

	// Core domain state.
	typedef struct packed {
		logic [12:0]                          pin_s1;
		logic [12:0]                          pin_s2;
		logic [2:0]                           tgl_s1;
		logic [2:0]                           tgl_s2;
		logic [2:0]                           tgl_s3;
		logic                                 csn_prev;
		hbp_pkg::mode_t                       mode;
		logic [W-1:0]                         mode_cnt;
		logic                                 ready;
		logic [hbp_pkg::N_COND-1:0][W-1:0]    filt_cnt;
		logic [3:0]                           oc_flag;
		logic [1:0]                           uld_flag;
		logic                                 sov_flag;
		logic                                 suv_flag;
		logic                                 tw_flag;
		logic                                 tsd_flag;
		logic [1:0][W-1:0]                    retry_cnt;
		logic [1:0][W-1:0]                    dead_cnt;
		logic [1:0]                           hs_q;
		logic [1:0]                           ls_q;
		logic [W-1:0]                         blank_cnt;
		logic [2:0]                           sel_prev;
		logic                                 sel_hs_prev;
		logic                                 sample_ok;
		hbp_pkg::sense_t                      sense_q;
	} core_state_t;

	link_state_t lq;      // Link domain registers.
	link_state_t nxt_lq;  // Their next value.
	core_state_t q;       // Core domain registers.
	core_state_t nxt_q;   // Their next value.

	// =====================================================================
	// Helper functions.

	// Filter length of condition number idx.
	function automatic logic [W-1:0] filt_len(input int unsigned idx);
		logic [W-1:0] len;
		len = W'(OC_FILTER_CYC);
		if (idx >= hbp_pkg::PIN_ULD && idx < hbp_pkg::PIN_SOV) begin
			len = W'(ULD_FILTER_CYC);
		end else if (idx == hbp_pkg::PIN_SOV || idx == hbp_pkg::PIN_SUV) begin
			len = W'(SUPPLY_FILTER_CYC);
		end else if (idx == hbp_pkg::PIN_TW || idx == hbp_pkg::PIN_TSD) begin
			len = W'(THERMAL_FILTER_CYC);
		end
		return len;
	endfunction

	// Recovery time for a rate select: one to four base periods.
	function automatic logic [W-1:0] retry_len(input logic [1:0] rate);
		int unsigned cyc;
		cyc = RETRY_BASE_CYC * (int'(rate) + 1);
		return W'(cyc);
	endfunction

	// One-hot output route for a sense select code; other codes route nothing.
	function automatic logic [1:0] sense_route(input logic [2:0] sel);
		logic [1:0] r;
		r = 2'h0;
		if (sel == hbp_pkg::SENSE_SEL_OUT1) begin
			r = 2'h1;
		end else if (sel == hbp_pkg::SENSE_SEL_OUT2) begin
			r = 2'h2;
		end
		return r;
	endfunction

	// =====================================================================
	// Link domain: read-and-clear decode.

	// Each read-and-clear of a status register flips its toggle; the core
	// sees the flip as one clear event. A toggle survives the link clock
	// stopping between frames, where a pulse would not.
	always_comb begin
		nxt_lq = lq;
		nxt_lq.rst_s1 = rst_n;
		nxt_lq.rst_s2 = lq.rst_s1;
		if (!lq.rst_s2) begin
			nxt_lq.clr_tgl = 3'h0;
		end else if (cmd_valid && cmd_opcode == hbp_pkg::OP_READ_CLEAR) begin
			if (cmd_addr == hbp_pkg::ADDR_OC_STAT) begin
				nxt_lq.clr_tgl[0] = ~lq.clr_tgl[0];
			end
			if (cmd_addr == hbp_pkg::ADDR_ULD_STAT) begin
				nxt_lq.clr_tgl[1] = ~lq.clr_tgl[1];
			end
			if (cmd_addr == hbp_pkg::ADDR_SUP_STAT) begin
				nxt_lq.clr_tgl[2] = ~lq.clr_tgl[2];
			end
		end
	end

	// Link registers; reset arrives through the two-stage synchroniser above.
	always_ff @(posedge link_clk) begin
		lq <= nxt_lq;
	end

	// =====================================================================
	// Core domain: protection, mode and sense control.

	logic [2:0]                  clr_ev;     // One-cycle clear events.
	logic                        csn;        // Synchronised chip select.
	logic                        cs_fall;    // Frame start.
	logic                        cs_rise;    // Frame end.
	logic [hbp_pkg::N_COND-1:0]  cond;       // Raw conditions after sync.
	logic [hbp_pkg::N_COND-1:0]  fok;        // Conditions past their filter.
	logic [1:0]                  pwm;        // Synchronised PWM inputs.
	logic [1:0]                  retry_done; // Recovery time elapsed.
	logic                        supply_block;
	logic [1:0]                  out_en;     // Output may drive.
	logic [1:0]                  want_hs;
	logic [1:0]                  want_ls;
	logic [1:0]                  route;
	logic                        cur_hs;
	logic                        sel_change;
	logic [W-1:0]                blank_len;
	logic                        track;

	// The whole next state of the core is worked out here.
	always_comb begin
		nxt_q = q;

		// Two flip-flops on every pin; only the second stage is read below.
		nxt_q.pin_s1 = pins;
		nxt_q.pin_s2 = q.pin_s1;
		nxt_q.tgl_s1 = lq.clr_tgl;
		nxt_q.tgl_s2 = q.tgl_s1;
		nxt_q.tgl_s3 = q.tgl_s2;
		clr_ev = q.tgl_s2 ^ q.tgl_s3;

		csn = q.pin_s2[hbp_pkg::PIN_CSN];
		cs_fall = q.csn_prev & ~csn;
		cs_rise = ~q.csn_prev & csn;
		nxt_q.csn_prev = csn;
		pwm = q.pin_s2[hbp_pkg::PIN_PWM +: 2];

		// Underload is only meaningful while a transistor of that output conducts.
		cond = q.pin_s2[hbp_pkg::N_COND-1:0];
		cond[hbp_pkg::PIN_ULD +: 2] = q.pin_s2[hbp_pkg::PIN_ULD +: 2] & (q.hs_q | q.ls_q);

		// Filters count while a condition holds and restart when it drops.
		for (int i = 0; i < hbp_pkg::N_COND; i++) begin
			fok[i] = (q.filt_cnt[i] == filt_len(i));
			if (!cond[i]) begin
				nxt_q.filt_cnt[i] = '0;
			end else if (!fok[i]) begin
				nxt_q.filt_cnt[i] = q.filt_cnt[i] + W'(1);
			end
		end

		// Recovery timers, one per half-bridge, run while retry is chosen
		// and a stage of that output is flagged.
		for (int x = 0; x < 2; x++) begin
			retry_done[x] = 1'b0;
			if (!ctrl.overcurrent_retry_select[x] || !(|q.oc_flag[2*x +: 2])) begin
				nxt_q.retry_cnt[x] = '0;
			end else if (q.retry_cnt[x] == retry_len(ctrl.retry_rate_sel[x])) begin
				retry_done[x] = 1'b1;
				nxt_q.retry_cnt[x] = '0;
			end else begin
				nxt_q.retry_cnt[x] = q.retry_cnt[x] + W'(1);
			end
		end

		// Overcurrent flags per stage (even index low side, odd high side).
		// A new detection wins over a clear in the same cycle.
		for (int i = 0; i < 4; i++) begin
			nxt_q.oc_flag[i] = fok[hbp_pkg::PIN_OC + i] |
				(q.oc_flag[i] & ~(clr_ev[0] | retry_done[i/2]));
		end

		// Underload flags are sticky; a clear spares a channel still under load.
		for (int x = 0; x < 2; x++) begin
			nxt_q.uld_flag[x] = fok[hbp_pkg::PIN_ULD + x] |
				(q.uld_flag[x] & ~(clr_ev[1] & ~cond[hbp_pkg::PIN_ULD + x]));
		end

		// Supply flags: only the supply read-and-clear or Standby resets them.
		nxt_q.sov_flag = fok[hbp_pkg::PIN_SOV] | (q.sov_flag & ~clr_ev[2]);
		nxt_q.suv_flag = fok[hbp_pkg::PIN_SUV] | (q.suv_flag & ~clr_ev[2]);

		// The warning follows the filtered temperature and steers nothing.
		nxt_q.tw_flag = fok[hbp_pkg::PIN_TW];

		// Shutdown latches; only the return to Standby below clears it.
		nxt_q.tsd_flag = fok[hbp_pkg::PIN_TSD] | q.tsd_flag;

		// Mode sequence. Chip select edges are seen on the synchronised pin,
		// so the mode bit is sampled as the frame closes.
		case (q.mode)
			hbp_pkg::MODE_STANDBY: begin
				nxt_q.mode_cnt = '0;
				if (cs_fall) begin
					nxt_q.mode = hbp_pkg::MODE_WAKE;
				end
			end
			hbp_pkg::MODE_WAKE: begin
				if (q.mode_cnt != W'(WAKE_READY_CYC)) begin
					nxt_q.mode_cnt = q.mode_cnt + W'(1);
				end else begin
					nxt_q.ready = 1'b1;
				end
				if (cs_rise) begin
					nxt_q.mode_cnt = '0;
					nxt_q.mode = ctrl.mode_bit ? hbp_pkg::MODE_STARTUP : hbp_pkg::MODE_LEAVING;
				end
			end
			hbp_pkg::MODE_STARTUP: begin
				nxt_q.mode_cnt = q.mode_cnt + W'(1);
				if (cs_rise && !ctrl.mode_bit) begin
					nxt_q.mode_cnt = '0;
					nxt_q.mode = hbp_pkg::MODE_LEAVING;
				end else if (q.mode_cnt == W'(STARTUP_CYC - 1)) begin
					nxt_q.mode_cnt = '0;
					nxt_q.mode = hbp_pkg::MODE_ACTIVE;
				end
			end
			hbp_pkg::MODE_ACTIVE: begin
				nxt_q.mode_cnt = '0;
				if (cs_rise && !ctrl.mode_bit) begin
					nxt_q.mode = hbp_pkg::MODE_LEAVING;
				end
			end
			hbp_pkg::MODE_LEAVING: begin
				nxt_q.mode_cnt = q.mode_cnt + W'(1);
				if (cs_rise && ctrl.mode_bit) begin
					nxt_q.mode_cnt = '0;
					nxt_q.mode = hbp_pkg::MODE_STARTUP;
				end else if (q.mode_cnt == W'(STANDBY_RETURN_CYC - 1)) begin
					nxt_q.mode_cnt = '0;
					nxt_q.mode = hbp_pkg::MODE_STANDBY;
				end
			end
			default: begin
				nxt_q.mode_cnt = '0;
				nxt_q.mode = hbp_pkg::MODE_STANDBY;
			end
		endcase

		// With recovery select at 1 a logged supply fault keeps the outputs
		// off until the flags are cleared; at 0 only the live fault does.
		supply_block = fok[hbp_pkg::PIN_SOV] | fok[hbp_pkg::PIN_SUV] |
			(ctrl.supply_fault_recovery_select & (q.sov_flag | q.suv_flag));

		// Per output: commanded gates, with the PWM input folded in.
		for (int x = 0; x < 2; x++) begin
			// The next flag values are used, so a gate drops on the very edge at
			// which its fault flag rises and never conducts beside a set flag.
			out_en[x] = (q.mode == hbp_pkg::MODE_ACTIVE) & ~supply_block &
				~nxt_q.tsd_flag & ~(|nxt_q.oc_flag[2*x +: 2]);
			if (ctrl.out_pwm_en[x]) begin
				want_hs[x] = pwm[x] & ctrl.out_hs[x];
				want_ls[x] = pwm[x] ? (ctrl.out_ls[x] & ~ctrl.out_hs[x]) :
					(ctrl.out_ls[x] & ctrl.out_hs[x]);
			end else begin
				want_hs[x] = ctrl.out_hs[x] & ~ctrl.out_ls[x];
				want_ls[x] = ctrl.out_ls[x] & ~ctrl.out_hs[x];
			end

			// Dead time counts while both gates are off; a gate may only rise
			// once it has run out, so the two never overlap.
			if (q.hs_q[x] || q.ls_q[x]) begin
				nxt_q.dead_cnt[x] = '0;
			end else if (q.dead_cnt[x] != W'(DEAD_CYC)) begin
				nxt_q.dead_cnt[x] = q.dead_cnt[x] + W'(1);
			end
			nxt_q.hs_q[x] = out_en[x] & want_hs[x] & ~q.ls_q[x] &
				(q.hs_q[x] | (q.dead_cnt[x] == W'(DEAD_CYC)));
			nxt_q.ls_q[x] = out_en[x] & want_ls[x] & ~q.hs_q[x] &
				(q.ls_q[x] | (q.dead_cnt[x] == W'(DEAD_CYC)));
		end

		// Current sense: route, blanking after switch-on, sample and hold.
		route = sense_route(ctrl.sense_channel_select);
		cur_hs = |(route & q.hs_q);
		sel_change = (ctrl.sense_channel_select != q.sel_prev);
		nxt_q.sel_prev = ctrl.sense_channel_select;
		nxt_q.sel_hs_prev = cur_hs;
		blank_len = (|(route & ctrl.out_pwm_en)) ? W'(BLANK_PWM_CYC) : W'(BLANK_CYC);
		if (sel_change || (cur_hs && !q.sel_hs_prev) || !cur_hs) begin
			nxt_q.blank_cnt = '0;
		end else if (q.blank_cnt != blank_len) begin
			nxt_q.blank_cnt = q.blank_cnt + W'(1);
		end
		track = cur_hs & !sel_change & (q.blank_cnt == blank_len);

		// A new channel starts with no sample, so it reports zero until it
		// has tracked once.
		if (sel_change) begin
			nxt_q.sample_ok = 1'b0;
		end else if (track) begin
			nxt_q.sample_ok = 1'b1;
		end
		nxt_q.sense_q.route = route;
		nxt_q.sense_q.track = track;
		nxt_q.sense_q.hold = ~track & q.sample_ok & ~sel_change;
		nxt_q.sense_q.zero = ~track & ~(q.sample_ok & ~sel_change);

		// Standby clears every flag but the warning, and the recovery timers, and leaves all outputs open.
		if (q.mode == hbp_pkg::MODE_STANDBY) begin
			nxt_q.ready = 1'b0;
			nxt_q.oc_flag = 4'h0;
			nxt_q.uld_flag = 2'h0;
			nxt_q.sov_flag = 1'b0;
			nxt_q.suv_flag = 1'b0;
			nxt_q.tsd_flag = 1'b0;
			nxt_q.retry_cnt = '0;
			nxt_q.hs_q = 2'h0;
			nxt_q.ls_q = 2'h0;
		end
	end

	// Core registers; reset still acts, but otherwise the clock enable freezes everything while low.
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			q <= '0;
			q.mode <= hbp_pkg::MODE_STANDBY;
		end else if (clk_en) begin
			q <= nxt_q;
		end
	end

	// =====================================================================
	// Outputs.

	// Gates and flags come straight from flip-flops, save the global flag below.
	assign drive.hs = q.hs_q;
	assign drive.ls = q.ls_q;
	assign sense = q.sense_q;
	assign mode_state = q.mode;
	assign spi_ready = q.ready;
	assign standby_clear = (q.mode == hbp_pkg::MODE_STANDBY);

	assign status.per_driver_overcurrent_flags = q.oc_flag;
	assign status.per_channel_underload_flags = q.uld_flag;
	assign status.supply_over_flag = q.sov_flag;
	assign status.supply_under_flag = q.suv_flag;
	assign status.thermal_warning_flag = q.tw_flag;
	assign status.thermal_shutdown_flag = q.tsd_flag;
	// The global flag carries any overcurrent and either supply fault.
	assign status.global_supply_or_overcurrent_flag =
		(|q.oc_flag) | q.sov_flag | q.suv_flag;

endmodule

`default_nettype wire

// ### sim/mcu_link.sv
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Controller model: issues one read-and-clear command per req toggle.
module mcu_link (
	input  wire logic       link_clk,
	input  wire logic       req,
	input  wire logic [5:0] addr_in,
	output var  logic       cmd_valid,
	output var  logic [1:0] cmd_opcode,
	output var  logic [5:0] cmd_addr
);
	logic seen = 1'b0; // Last request served.
	initial begin
		cmd_valid = 1'b0;
		cmd_opcode = 2'h1;
		cmd_addr = 6'h2a;
	end
	// Outside the valid cycle the fields toggle, so stale values match the real command only every second cycle.
	always @(posedge link_clk) begin
		if (req != seen && !cmd_valid) begin
			seen <= req;
			cmd_valid <= 1'b1;
			cmd_opcode <= 2'h2;
			cmd_addr <= addr_in;
		end else begin
			cmd_valid <= 1'b0;
			cmd_opcode <= ~cmd_opcode;
			cmd_addr <= ~cmd_addr;
		end
	end
endmodule
`default_nettype wire

// ### sim/hbp_checker.sv
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// Port checker on the core clock; a frozen core simply holds its outputs.
module hbp_checker (
	input wire logic             ref_clk,
	input wire logic             rst_n,
	input wire hbp_pkg::pins_t   pins,
	input wire hbp_pkg::ctrl_t   ctrl,
	input wire hbp_pkg::sense_t  sense,
	input wire hbp_pkg::drive_t  drive,
	input wire hbp_pkg::status_t status,
	input wire hbp_pkg::mode_t   mode_state,
	input wire logic             spi_ready,
	input wire logic             standby_clear
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	glob_or_a: assert property (status.global_supply_or_overcurrent_flag ==
		|{status.per_driver_overcurrent_flags, status.supply_over_flag, status.supply_under_flag})
		else $error("global flag mismatch");
	oc_off0_a: assert property (|status.per_driver_overcurrent_flags[1:0] |-> !drive.hs[0] && !drive.ls[0])
		else $error("output 0 driven while flagged");
	oc_off1_a: assert property (|status.per_driver_overcurrent_flags[3:2] |-> !drive.hs[1] && !drive.ls[1])
		else $error("output 1 driven while flagged");
	tsd_off_a: assert property (status.thermal_shutdown_flag |-> drive == '0)
		else $error("driven in thermal shutdown");
	sup_hold_a: assert property ((status.supply_over_flag || status.supply_under_flag) &&
		$past(ctrl.supply_fault_recovery_select) |-> drive == '0)
		else $error("driven with supply flag");
	sense_track_a: assert property (sense.track |-> |(sense.route & $past(drive.hs)))
		else $error("sense tracks an idle stage");
	stby_off_a: assert property (mode_state == hbp_pkg::MODE_STANDBY |-> drive == '0 && standby_clear)
		else $error("standby not quiet");
	dead_time_a: assert property ($rose(drive.hs[0]) |-> !$past(drive.ls[0]))
		else $error("no dead time");
	oc_filter_a: assert property ($rose(status.per_driver_overcurrent_flags[1]) |->
		$past(pins.overcurrent_raw[1], 4) && $past(pins.overcurrent_raw[1], 6))
		else $error("overcurrent flag without filter");
	tsd_latch_a: assert property ($fell(status.thermal_shutdown_flag) |->
		mode_state inside {hbp_pkg::MODE_LEAVING, hbp_pkg::MODE_STANDBY})
		else $error("thermal shutdown released early");
	wake_rdy_a: assert property ($rose(spi_ready) |-> mode_state == hbp_pkg::MODE_WAKE)
		else $error("ready outside wake");
	cover property ($rose(status.per_driver_overcurrent_flags[0]));
	cover property ($rose(status.thermal_shutdown_flag));
	cover property (mode_state == hbp_pkg::MODE_ACTIVE ##1 mode_state == hbp_pkg::MODE_LEAVING);
endmodule
bind half_bridge_protection_mode_ctrl hbp_checker u_chk (.ref_clk, .rst_n, .pins, .ctrl,
	.sense, .drive, .status, .mode_state, .spi_ready, .standby_clear);
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic ref_clk = 0, link_clk = 0, link_on = 1, rst_n = 0, req = 0, clk_en = 1;
	logic [5:0] rc_addr = 6'h00;
	logic [31:0] rs = 32'h00017140;
	int mismatches = 0, tests_run = 0;
	hbp_pkg::pins_t pins;
	hbp_pkg::ctrl_t ctrl;
	hbp_pkg::drive_t drive;
	hbp_pkg::sense_t sense;
	hbp_pkg::status_t status, e, last_s, sq[$];
	hbp_pkg::mode_t mode_state, last_m, mq[$];
	logic spi_ready, standby_clear, cmd_valid;
	logic [1:0] op;
	logic [5:0] ad;
	always #4 ref_clk = ~ref_clk;
	// The link clock stands still between frames.
	always #6 link_clk = link_on ? ~link_clk : 1'b0;
	// Only the startup time, the overcurrent, supply and thermal filters and the retry base are shortened.
	half_bridge_protection_mode_ctrl #(.STARTUP_CYC(40), .OC_FILTER_CYC(4),
		.SUPPLY_FILTER_CYC(6), .THERMAL_FILTER_CYC(6),
		.RETRY_BASE_CYC(30)) u_half_bridge_protection_mode_ctrl (
		.ref_clk, .rst_n, .clk_en, .link_clk, .cmd_valid, .cmd_opcode(op),
		.cmd_addr(ad), .pins, .ctrl, .drive, .status, .sense, .mode_state, .spi_ready,
		.standby_clear);
	mcu_link u_mcu_link (.link_clk, .req, .addr_in(rc_addr), .cmd_valid, .cmd_opcode(op),
		.cmd_addr(ad));
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// Notes the expected flags, with the global flag worked out here.
	task automatic push();
		e.global_supply_or_overcurrent_flag = |{e.per_driver_overcurrent_flags,
			e.supply_over_flag, e.supply_under_flag};
		sq.push_back(e);
	endtask
	task automatic rc(input logic [5:0] a);
		rc_addr = a;
		link_on = 1;
		req = ~req;
		repeat (4) @(posedge link_clk);
		link_on = 0;
		cyc(8);
	endtask
	task automatic cond(input int b, input int n);
		pins[b] = 1'b1;
		cyc(n);
		pins[b] = 1'b0;
		cyc(10);
	endtask
	task automatic frame(input logic m);
		pins.chip_select_n = 0;
		cyc(hbp_pkg::WAKE_READY_CYC + 20);
		ctrl.mode_bit = m;
		pins.chip_select_n = 1;
		cyc(60);
	endtask
	task automatic cmp_status(input hbp_pkg::status_t x, input hbp_pkg::status_t s);
		tests_run++;
		if (x !== s) begin
			mismatches++;
			$display("Error status expected %h seen %h", x, s);
		end
	endtask
	task automatic cmp_mode(input hbp_pkg::mode_t x, input hbp_pkg::mode_t s);
		tests_run++;
		if (x !== s) begin
			mismatches++;
			$display("Error mode_state expected %h seen %h", x, s);
		end
	endtask
	task automatic results();
		if (sq.size() || mq.size()) mismatches++; // Unused notes mean missing results.
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Every change of flags or mode takes the oldest note; an empty queue fails.
	always @(posedge ref_clk) begin
		#2;
		if (!rst_n) begin
			last_s = status;
			last_m = mode_state;
		end else begin
			if (status !== last_s) cmp_status(sq.size() ? sq.pop_front() : ~status, status);
			if (mode_state !== last_m) cmp_mode(mq.size() ? mq.pop_front() : hbp_pkg::mode_t'(~mode_state), mode_state);
			last_s = status;
			last_m = mode_state;
		end
	end
	initial begin
		#150000; // About three times the expected run.
		mismatches++;
		results();
	end
	initial begin
		pins = '0;
		pins.chip_select_n = 1;
		ctrl = '0;
		ctrl.sense_channel_select = hbp_pkg::SENSE_SEL_OUT1;
		ctrl.out_pwm_en = 2'h1;
		pins.pwm_in = 2'h3;
		e = '0;
		cyc(10);
		rst_n = 1;
		cyc(4); // Let the link side see the release before its clock stops.
		link_on = 0;
		mq = '{hbp_pkg::MODE_WAKE, hbp_pkg::MODE_STARTUP, hbp_pkg::MODE_ACTIVE};
		frame(1);
		$display("wake done");
		rs = xs(rs);
		ctrl.retry_rate_sel = rs[3:0];
		ctrl.out_hs = 2'h1;
		cond(hbp_pkg::PIN_OC + 1, 2); // Too short: refused.
		e.per_driver_overcurrent_flags = 4'h2;
		push();
		cond(hbp_pkg::PIN_OC + 1, 20);
		rc(6'h13); // Unmapped address: ignored.
		clk_en = 0; // A frozen core must not act on the clear yet.
		rc(hbp_pkg::ADDR_OC_STAT);
		cmp_status(e, status);
		clk_en = 1;
		e = '0;
		push();
		cyc(8);
		ctrl.overcurrent_retry_select = 2'h1;
		e.per_driver_overcurrent_flags = 4'h1;
		push();
		e = '0;
		push();
		cond(hbp_pkg::PIN_OC, 10);
		cyc(130);
		$display("overcurrent done");
		ctrl.supply_fault_recovery_select = 1;
		for (int i = 0; i < 2; i++) begin
			e.supply_over_flag = (i == 0);
			e.supply_under_flag = (i == 1);
			push();
			cond(hbp_pkg::PIN_SOV + i, 20);
			rc(hbp_pkg::ADDR_OC_STAT); // Wrong register keeps the flag.
			e = '0;
			push();
			rc(hbp_pkg::ADDR_SUP_STAT);
		end
		$display("supply done");
		e.per_channel_underload_flags = 2'h1;
		push();
		pins[hbp_pkg::PIN_ULD] = 1;
		cyc(hbp_pkg::ULD_FILTER_CYC + 10);
		rc(hbp_pkg::ADDR_ULD_STAT); // Still live: spared.
		pins[hbp_pkg::PIN_ULD] = 0;
		e = '0;
		push();
		rc(hbp_pkg::ADDR_ULD_STAT);
		e.thermal_warning_flag = 1;
		push();
		e = '0;
		push();
		cond(hbp_pkg::PIN_TW, 20);
		$display("underload and warning done");
		e.thermal_shutdown_flag = 1;
		push();
		cond(hbp_pkg::PIN_TSD, 20);
		e = '0;
		push();
		mq = '{hbp_pkg::MODE_LEAVING, hbp_pkg::MODE_STANDBY};
		frame(0);
		cyc(hbp_pkg::STANDBY_RETURN_CYC + 20);
		$display("shutdown done");
		results();
	end
endmodule
`default_nettype wire
